/* File: verilog/ptb_bridge.sv */
// Purpose: pass-thru sequential region to 16-bit host port bridge
// Assumes: add-on pass-thru inputs synchronous to mclk; host ready asynchronous
// Notes:   only the sequential block region is served; no address phase
//
// Functional notes
// [RULE1] sequential accesses force auto-increment access select
// [RULE2] host port reads advance address and prefetch
// [RULE3] host port writes advance address automatically
// [RULE4] software loads host address once first
// [RULE5] address strobe never asserted or released
// [RULE6] every region access targets host data register
// [RULE7] sample attention and burst after each word
// [RULE8] zero/zero: access next word immediately
// [RULE9] zero/one: perform exactly one final access
// [RULE10] one/zero: wait for attention low
// [RULE11] one/one: return idle, await attention
// [RULE12] write indicator chooses read or write
// [RULE13] reads follow single register read sequence
// [RULE14] writes follow single register write sequence
// [RULE15] state machine synchronous, one clock between edges
// [RULE16] each word moves as two halfwords
// [RULE17] software keeps accesses inside region
// [RULE18] wait on host ready, no fixed delay
// [RULE19] synchronise host ready before sampling it
// [RULE20] halfword select low then high, no wait
// [RULE21] pulse pass-thru ready after both halfwords
// [RULE22] reset: idle, selects, strobe, ready inactive
`timescale 1ns/1ps
module ptb_bridge (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  // pass-thru side
  input  wire logic                     passthru_attention_n,
  input  wire logic                     passthru_burst_last,
  input  wire logic                     passthru_write_indicator,
  output logic                          passthru_address_strobe_n,
  output logic                          passthru_ready_out_n,
  input  wire logic [ptb_pkg::WORD_W-1:0] wr_word,
  output logic      [ptb_pkg::WORD_W-1:0] rd_word,
  output logic                          rd_word_valid,
  input  wire logic                     rd_word_ready,
  // host port side
  output ptb_pkg::ptb_host_ctl_type     host_ctl,
  input  wire logic                     host_port_ready_n,
  input  wire logic [ptb_pkg::HALF_W-1:0] host_data_in,
  output logic      [ptb_pkg::HALF_W-1:0] host_data_out,
  output logic                          host_data_oe_n
);
  import ptb_pkg::*;

  // ---------------------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_SELECT, ST_HW1_SETUP, ST_HW1_STROBE, ST_HW2_SETUP,
    ST_HW2_STROBE, ST_HW2_END, ST_DONE, ST_DECIDE, ST_WAIT
  } ptb_state_type;

  ptb_state_type         state_q, state_d;   // sequencer state
  ptb_host_ctl_type      ctl_q, ctl_d;       // host control pins
  logic                  rdy_n_q, rdy_n_d;   // pass-thru ready, active low
  logic [HALF_W-1:0]     lo_q, lo_d;         // first halfword read back
  logic [HALF_W-1:0]     hdo_q, hdo_d;       // host data driven out
  logic                  oe_n_q, oe_n_d;     // host data enable, low = drive
  logic [WORD_W-1:0]     wr_q, wr_d;         // write word held for both halves
  logic                  is_wr_q, is_wr_d;   // current transfer is a write
  logic                  last_q, last_d;     // final transfer of a burst
  logic [1:0]            hold_q, hold_d;     // strobe cycles before ready is trusted
  logic                  push;               // hand read word to buffer
  logic                  buf_in_ready;       // buffer can take a word
  logic [SYNC_STAGES-1:0] host_port_ready_sync_q;       // ready synchroniser chain
  logic                  host_ready;         // synchronised ready, high = ready
  ptb_pt_stat_type       stat;               // sampled pass-thru status

  assign stat = '{attention_n: passthru_attention_n,
                  burst_last: passthru_burst_last,
                  write: passthru_write_indicator};

  // ---------------------------------------------------------------------------
  // ready synchroniser
  // ---------------------------------------------------------------------------
  // first stage feeds only the second; the sequencer reads the last stage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      host_port_ready_sync_q <= '1;
    end else begin
      host_port_ready_sync_q <= {host_port_ready_sync_q[SYNC_STAGES-2:0], host_port_ready_n};  // [RULE19]
    end
  end
  assign host_ready = ~host_port_ready_sync_q[SYNC_STAGES-1];

  // ---------------------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------------------
  // every output changes on an mclk edge only, so edges sit a clock apart
  always_comb begin
    state_d = state_q;
    ctl_d   = ctl_q;
    rdy_n_d = 1'b1;
    lo_d    = lo_q;
    hdo_d   = hdo_q;
    oe_n_d  = oe_n_q;
    wr_d    = wr_q;
    is_wr_d = is_wr_q;
    last_d  = last_q;
    hold_d  = hold_q;
    push    = 1'b0;
    unique case (state_q)
      // idle until attention shows a region transfer
      ST_IDLE: begin
        last_d = 1'b0;
        if (!stat.attention_n) begin
          state_d = ST_SELECT;  // no address phase [RULE5] [RULE6]
        end
      end
      // enable host port and latch direction
      ST_SELECT: begin
        is_wr_d          = stat.write;  // [RULE12]
        wr_d             = wr_word;
        ctl_d.select_n   = 1'b0;
        ctl_d.read       = ~stat.write;
        ctl_d.access     = HOST_CNTL_AUTOINC;  // [RULE1] [RULE2] [RULE3]
        state_d          = ST_HW1_SETUP;
      end
      // first halfword setup
      ST_HW1_SETUP: begin
        ctl_d.halfword = 1'b0;  // [RULE20]
        hold_d         = 2'(SYNC_STAGES);  // ready seen now predates the strobe
        ctl_d.strobe_n = 1'b0;
        if (is_wr_q) begin
          hdo_d  = wr_q[HALF_W-1:0];  // [RULE14]
          oe_n_d = 1'b0;
        end
        state_d = ST_HW1_STROBE;
      end
      // hold strobe until the port reports ready; for the first cycles the
      // synchroniser still shows the ready level from before the strobe,
      // which would let a pending prefetch slip past unnoticed
      ST_HW1_STROBE: begin
        if (hold_q != 2'h0) begin
          hold_d = hold_q - 2'h1;  // [RULE19]
        end else if (host_ready) begin  // [RULE18] [RULE13]
          lo_d           = host_data_in;
          ctl_d.strobe_n = 1'b1;
          ctl_d.halfword = 1'b1;  // [RULE16]
          if (is_wr_q) begin
            hdo_d = wr_q[WORD_W-1:HALF_W];
          end
          state_d = ST_HW2_SETUP;
        end
      end
      // second halfword goes straight out, no ready check
      ST_HW2_SETUP: begin
        ctl_d.strobe_n = 1'b0;  // [RULE20]
        state_d        = ST_HW2_STROBE;
      end
      // end second halfword and capture the upper half
      ST_HW2_STROBE: begin
        ctl_d.strobe_n = 1'b1;
        oe_n_d         = 1'b1;
        state_d        = ST_HW2_END;
      end
      // read words wait here while the buffer is full
      ST_HW2_END: begin
        if (is_wr_q || buf_in_ready) begin
          push           = ~is_wr_q;
          ctl_d.select_n = 1'b1;
          rdy_n_d        = 1'b0;  // [RULE21]
          state_d        = ST_DONE;
        end
      end
      // controller sees ready this cycle
      ST_DONE: begin
        state_d = ST_DECIDE;
      end
      // choose the next action from attention and burst
      ST_DECIDE: begin
        if (last_q) begin
          state_d = ST_IDLE;
        end else if (!stat.attention_n) begin
          last_d  = stat.burst_last;  // [RULE7] [RULE9]
          state_d = ST_SELECT;        // [RULE8]
        end else if (!stat.burst_last) begin
          state_d = ST_WAIT;          // [RULE10]
        end else begin
          state_d = ST_IDLE;          // [RULE11]
        end
      end
      // burst continues, controller not yet ready
      ST_WAIT: begin
        if (!stat.attention_n) begin
          last_d  = stat.burst_last;
          state_d = ST_SELECT;  // [RULE10]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin  // [RULE15]
    if (reset) begin
      state_q <= ST_IDLE;  // [RULE22]
      ctl_q   <= HOST_CTL_IDLE;
      rdy_n_q <= 1'b1;
      lo_q    <= '0;
      hdo_q   <= '0;
      oe_n_q  <= 1'b1;
      wr_q    <= '0;
      is_wr_q <= 1'b0;
      last_q  <= 1'b0;
      hold_q  <= '0;
    end else begin
      state_q <= state_d;
      ctl_q   <= ctl_d;
      rdy_n_q <= rdy_n_d;
      lo_q    <= lo_d;
      hdo_q   <= hdo_d;
      oe_n_q  <= oe_n_d;
      wr_q    <= wr_d;
      is_wr_q <= is_wr_d;
      last_q  <= last_d;
      hold_q  <= hold_d;
    end
  end

  // ---------------------------------------------------------------------------
  // read word buffer
  // ---------------------------------------------------------------------------
  // upper half is on the host bus during ST_HW2_END's entry edge
  logic [HALF_W-1:0] hi_q;  // second halfword read back
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hi_q <= '0;
    end else if (state_q == ST_HW2_STROBE) begin
      hi_q <= host_data_in;
    end
  end

  ptb_word_buf #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .mclk      (mclk),
    .reset     (reset),
    .in_data   ({hi_q, lo_q}),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .out_data  (rd_word),
    .out_valid (rd_word_valid),
    .out_ready (rd_word_ready)
  );

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign passthru_address_strobe_n = 1'b1;  // [RULE5]
  assign passthru_ready_out_n      = rdy_n_q;
  assign host_ctl                  = ctl_q;
  assign host_data_out             = hdo_q;
  assign host_data_oe_n            = oe_n_q;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_access_forced: assert property (!ctl_q.select_n |-> ctl_q.access == HOST_CNTL_AUTOINC)  // [RULE1]
    else $error("access select not auto-increment");
  a_no_addr_strobe: assert property (passthru_address_strobe_n)  // [RULE5]
    else $error("address strobe asserted");
  a_ready_waited: assert property ((state_q == ST_HW1_STROBE) && !host_ready |=> !ctl_q.strobe_n)  // [RULE18]
    else $error("strobe released before ready");
  a_ready_settle: assert property ((state_q == ST_HW1_STROBE) && (hold_q != 2'h0) |=> !ctl_q.strobe_n)  // [RULE19]
    else $error("stale ready accepted");
  a_second_no_wait: assert property ((state_q == ST_HW2_SETUP) |=> !ctl_q.strobe_n && ctl_q.halfword)  // [RULE20]
    else $error("second halfword delayed");
  a_ready_one_pulse: assert property ($fell(passthru_ready_out_n) |=> passthru_ready_out_n ##1 $stable(ctl_q.select_n))  // [RULE21]
    else $error("pass-thru ready not a single pulse");
  a_two_halves: assert property ($fell(passthru_ready_out_n) |-> $past(ctl_q.halfword, 2))  // [RULE16]
    else $error("ready before second halfword");
  a_burst_continue: assert property ((state_q == ST_DECIDE) && !last_q && !passthru_attention_n
                                     |=> state_q == ST_SELECT ##1 !ctl_q.select_n)  // [RULE8]
    else $error("burst did not continue");
  a_burst_final: assert property ((state_q == ST_DECIDE) && !last_q && !passthru_attention_n
                                  && passthru_burst_last |=> last_q)  // [RULE9]
    else $error("final transfer not marked");
  a_burst_wait: assert property ((state_q == ST_DECIDE) && !last_q && passthru_attention_n
                                 && !passthru_burst_last |=> state_q == ST_WAIT)  // [RULE10]
    else $error("did not wait for attention");
  a_burst_end: assert property ((state_q == ST_DECIDE) && !last_q && passthru_attention_n
                                && passthru_burst_last |=> state_q == ST_IDLE)  // [RULE11]
    else $error("burst end not idle");
  a_write_drives: assert property (!ctl_q.strobe_n && !ctl_q.read |-> !host_data_oe_n)  // [RULE12]
    else $error("write strobe without data drive");

endmodule : ptb_bridge

/* File: verilog/ptb_pkg.sv */
// Purpose: shared constants and types for the pass-thru to host-port block bridge
// Assumes: single clock domain, all add-on inputs synchronous to mclk
// Notes:   host-port ready is the only asynchronous input
package ptb_pkg;

  // ---------------------------------------------------------------------------
  // widths and encodings
  // ---------------------------------------------------------------------------
  localparam int unsigned WORD_W       = 32;   // pass-thru data word
  localparam int unsigned HALF_W       = 16;   // host port data width
  localparam int unsigned BUF_DEPTH    = 2;    // read-data buffer entries
  localparam int unsigned SYNC_STAGES  = 2;    // ready synchroniser length
  localparam logic [1:0]  HOST_CNTL_AUTOINC = 2'h2;  // auto-increment data access
  localparam logic [1:0]  HOST_CNTL_RESET   = 2'h2;  // access select after reset

  // ---------------------------------------------------------------------------
  // clock figures
  // ---------------------------------------------------------------------------
  localparam int unsigned MCLK_PERIOD_NS = 50;  // mclk period
  localparam int unsigned MIN_GAP_NS     = 30;  // least spacing of control edges
  localparam int unsigned MIN_GAP_CYC    =
    (MIN_GAP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;  // rounds up, at least one

  // ---------------------------------------------------------------------------
  // host-port control pins, all registered
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       select_n;   // host port select, active low
    logic       strobe_n;   // host data strobe, active low
    logic       halfword;   // halfword select, low = first
    logic       read;       // 1 = read, 0 = write
    logic [1:0] access;     // host access select
  } ptb_host_ctl_type;

  localparam ptb_host_ctl_type HOST_CTL_IDLE = '{select_n: 1'b1, strobe_n: 1'b1,
    halfword: 1'b0, read: 1'b1, access: HOST_CNTL_RESET};

  // ---------------------------------------------------------------------------
  // sampled pass-thru status
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic attention_n;  // pass-thru attention, low = pending transfer
    logic burst_last;   // high = one or no transfer left
    logic write;        // pass-thru write indicator
  } ptb_pt_stat_type;

endpackage : ptb_pkg

/* File: verilog/ptb_word_buf.sv */
// Purpose: small valid/ready buffer for assembled read words
// Assumes: depth is a power of two
// Notes:   full and empty come straight from the occupancy count
`timescale 1ns/1ps
module ptb_word_buf #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  import ptb_pkg::*;

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];   // storage
  logic [PW-1:0]    wp_q, wp_d;      // write pointer
  logic [PW-1:0]    rp_q, rp_d;      // read pointer
  logic [PW:0]      cnt_q, cnt_d;    // occupancy
  logic             push, pop;

  // ---------------------------------------------------------------------------
  // pointer and count update
  // ---------------------------------------------------------------------------
  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));  // full refuses, even while popping
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wp_d  = push ? wp_q + PW'(1) : wp_q;
    rp_d  = pop ? rp_q + PW'(1) : rp_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; only valid entries are ever read out
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule : ptb_word_buf

/* File: verification/ptb_host_model.sv */
// Purpose: host port partner, auto-increment memory behind a ready line
// Assumes: control pins change just after mclk edges
// Notes:   undriven read data shows an inverted, ever-changing pattern
`timescale 1ns/1ps
module ptb_host_model (
  input  wire logic                      mclk,
  input  wire ptb_pkg::ptb_host_ctl_type host_ctl,
  input  wire logic [15:0]               host_data_out,
  input  wire logic                      load,
  input  wire logic [7:0]                base,
  input  wire logic [5:0]                dly,
  output logic                           host_port_ready_n,
  output logic [15:0]                    host_data_in
);
  import ptb_pkg::*;
  logic [31:0] mem [0:255];  // device memory
  logic [7:0]  addr_q;       // host address register
  logic [15:0] lo_q;         // first half of a write
  logic [15:0] last_q;       // last value on the data lines
  logic [15:0] d_q;          // write data of the last cycle
  logic [5:0]  busy_q = '0;  // cycles until ready again
  logic        s_q = 1'b1;   // strobe inactive last cycle
  logic        h_q;          // halfword of the last cycle
  logic        r_q;          // direction of the last cycle
  logic        act;          // strobe active now
  // ---------------------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------------------
  assign act = !host_ctl.select_n && !host_ctl.strobe_n;
  assign host_data_in = (act && host_ctl.read) ?
    (host_ctl.halfword ? mem[addr_q][31:16] : mem[addr_q][15:0]) : ~last_q;
  // with dly nonzero, ready drops as soon as a first-halfword read strobe opens, so the bridge must wait
  assign host_port_ready_n = (busy_q != 0) ||
    (dly != 0 && act && s_q && host_ctl.read && !host_ctl.halfword);
  // ---------------------------------------------------------------------------
  // auto-increment state
  // ---------------------------------------------------------------------------
  always @(posedge mclk) begin
    last_q <= host_data_in;
    s_q    <= !act;
    d_q    <= host_data_out;
    h_q    <= host_ctl.halfword;
    r_q    <= host_ctl.read;
    if (busy_q != 0) begin
      busy_q <= busy_q - 6'd1;
    end
    if (s_q && act && host_ctl.read && !host_ctl.halfword && dly != 0) begin
      busy_q <= dly - 6'd1;  // prefetch in progress
    end
    if (!s_q && !act) begin
      if (!r_q && !h_q) begin
        lo_q <= d_q;
      end
      if (!r_q && h_q) begin
        mem[addr_q] <= {d_q, lo_q};
        busy_q      <= dly;  // write into memory in progress
      end
      if (h_q) begin
        addr_q <= addr_q + 8'd1;  // advance after each word
      end
    end
    if (load) begin
      addr_q <= base;  // address loaded once per block
    end
  end
endmodule : ptb_host_model

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the pass-thru block bridge
// Assumes: bench plays the pass-thru controller, the model the host port
// Notes:   each block is written, then read back through auto-increment
`timescale 1ns/1ps
module tb_top;
  import ptb_pkg::*;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic             att_n = 1'b1;     // attention, low = pending
  logic             burst = 1'b1;     // burst last
  logic             wr_ind = 1'b0;    // write indicator
  logic [31:0]      wr_word = '0;
  logic             rd_ready = 1'b0;
  logic             load = 1'b0;
  logic [7:0]       base = '0;
  logic [5:0]       dly = '0;
  logic             adr_n, rdy_n, rd_valid, hp_rdy_n, oe_n;
  logic [31:0]      rd_word;
  logic [15:0]      hd_in, hd_out;
  ptb_host_ctl_type ctl;
  int               miscompares = 0;
  int               checks_done = 0;
  int               seed = 32'hbf8c_82f3;
  int               pulses = 0;       // ready pulses seen
  int               cyc = 0;
  int               stall_until = 0;  // receiver stalls until this cycle
  logic             hw_exp = 1'b0;    // next expected halfword
  logic             sprev = 1'b1;
  logic [31:0]      wdat [8];
  logic [31:0]      expq [$];
  ptb_bridge dut (.mclk(mclk), .reset(reset), .passthru_attention_n(att_n), .passthru_burst_last(burst),
    .passthru_write_indicator(wr_ind), .passthru_address_strobe_n(adr_n), .passthru_ready_out_n(rdy_n),
    .wr_word(wr_word), .rd_word(rd_word), .rd_word_valid(rd_valid), .rd_word_ready(rd_ready),
    .host_ctl(ctl), .host_port_ready_n(hp_rdy_n), .host_data_in(hd_in), .host_data_out(hd_out),
    .host_data_oe_n(oe_n));
  ptb_host_model hp (.mclk(mclk), .host_ctl(ctl), .host_data_out(hd_out), .load(load), .base(base),
    .dly(dly), .host_port_ready_n(hp_rdy_n), .host_data_in(hd_in));
  always #25 mclk = ~mclk;
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // {attention_n, burst_last} shown after word k of n
  function automatic logic [1:0] next_ctl(input int k, input int n);
    if (k < n - 1) return 2'b00;
    if (k == n - 1) return 2'b01;
    return 2'b11;
  endfunction : next_ctl
  // ---------------------------------------------------------------------------
  // pin monitor, sampled at the falling edge where all is settled
  // ---------------------------------------------------------------------------
  always @(negedge mclk) begin
    if (reset) begin
      chk("idle_ctl", 32'(HOST_CTL_IDLE), 32'(ctl));
      chk("ready_out", 1, 32'(rdy_n));
      chk("rd_valid", 0, 32'(rd_valid));
      hw_exp = 1'b0;
    end else begin
      chk("addr_strobe", 1, 32'(adr_n));
      if (!ctl.select_n) begin
        chk("access", 32'(HOST_CNTL_AUTOINC), 32'(ctl.access));
        chk("direction", 32'(!wr_ind), 32'(ctl.read));
      end
      if (!ctl.select_n && !ctl.strobe_n && sprev) begin
        chk("halfword", 32'(hw_exp), 32'(ctl.halfword));
        chk("drive", 32'(ctl.read), 32'(oe_n));
        hw_exp = ~hw_exp;
      end
      if (rdy_n === 1'b0) begin
        pulses++;
        chk("halves_done", 0, 32'(hw_exp));
      end
    end
    sprev = ctl.strobe_n | ctl.select_n;
  end
  // receiver of read words, stalling at random and on demand
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rd_ready <= (cyc >= stall_until) && ($random(seed) % 3 != 0);
    if (rd_valid === 1'b1 && rd_ready) begin
      if (expq.size() == 0) begin
        chk("extra_word", 0, 1);
      end else begin
        chk("rd_word", expq.pop_front(), rd_word);
      end
    end
  end
  task automatic load_addr(input int a);
    @(posedge mclk);
    base <= 8'(a);
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
  endtask : load_addr
  // one block of n words; a wait state follows word wait_at
  task automatic run_burst(input logic wr, input int n, input int a, input int wait_at);
    int cnt;
    load_addr(a);
    pulses = 0;
    if (!wr) for (int i = 0; i < n; i++) expq.push_back(wdat[i]);
    wr_ind <= wr;
    wr_word <= wdat[0];
    {att_n, burst} <= next_ctl(0, n);
    for (int k = 1; k <= n; k++) begin
      cnt = 0;
      @(negedge mclk);
      while (rdy_n !== 1'b0 && cnt < 4000) begin
        @(negedge mclk);
        cnt++;
      end
      @(posedge mclk);
      if (k == wait_at && k < n) begin
        {att_n, burst} <= 2'b10;
        repeat (8) begin
          @(negedge mclk);
          chk("wait_select", 1, 32'(ctl.select_n));
        end
        @(posedge mclk);
      end
      {att_n, burst} <= next_ctl(k, n);
      if (k < n) wr_word <= wdat[k];
    end
    cnt = 0;
    while ((expq.size() != 0 || cnt < 40) && cnt < 2000) begin
      @(posedge mclk);
      cnt++;
    end
    chk("drained", 0, 32'(expq.size()));
    chk("word_count", 32'(n), 32'(pulses));
    if (wr) for (int i = 0; i < n; i++) chk("host_mem", wdat[i], hp.mem[8'(a + i)]);
  endtask : run_burst
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    int n;
    int a;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) wdat[i] = $random(seed);
    run_burst(1'b1, 6, 16, 3);  // prompt host, wait state mid-block
    dly <= 6'd20;  // slow host, ready seen through the synchroniser
    stall_until <= cyc + 300;  // receiver stalls for 300 cycles, well past the point where the buffer refuses
    run_burst(1'b0, 6, 16, 2);
    run_burst(1'b1, 1, 255, 0);  // single word at the top address
    run_burst(1'b0, 1, 255, 0);
    reset <= 1'b1;  // reset in mid-run
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int r = 0; r < 6; r++) begin
      n = 1 + ($random(seed) & 7);
      a = $random(seed) & 255;  // stays inside the region
      dly <= 6'($random(seed) & 31);
      for (int i = 0; i < 8; i++) wdat[i] = $random(seed);
      run_burst(1'b1, n, a, $random(seed) & 7);
      run_burst(1'b0, n, a, $random(seed) & 7);
    end
    finish_test();
  end
  // watchdog, far beyond the longest expected run
  initial begin
    #(50 * 60000);
    miscompares++;
    finish_test();
  end
endmodule : tb_top
